// *** rtl/dcsl_pkg.sv ***
// constants and types of the drive control signal logic
package dcsl_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int PULSE_MIN_MS = 32;
    localparam int MS_CNT_W = 18;
    localparam int PMS_W = 6;
    localparam int NUM_IN = 6;
    localparam int NUM_LOGIC = 2;
    localparam int POOL_W = 16;
    localparam int SEL_W = 4;
    localparam int NUM_FUNC = 16;
    localparam int NUM_TMR = 2;
    localparam int TIME_W = 16;
    localparam int MP_W = 16;
    // pool positions
    localparam int P_IN = 0;
    localparam int P_INV = 6;
    localparam int P_TMR = 12;
    localparam int P_LOGIC = 14;
    localparam int IN_FOUR = 3;
    // function indices
    localparam int F_CW = 0;
    localparam int F_CCW = 1;
    localparam int F_3W = 2;
    localparam int F_ACK = 3;
    localparam int F_T1 = 4;
    localparam int F_T2 = 5;
    localparam int F_THERMO = 6;
    localparam int F_NM = 7;
    localparam int F_DS1 = 8;
    localparam int F_DS2 = 9;
    localparam int F_FF1 = 10;
    localparam int F_FF2 = 11;
    localparam int F_FP1 = 12;
    localparam int F_FP2 = 13;
    localparam int F_MPUP = 14;
    localparam int F_MPDN = 15;
    // configuration codes
    localparam logic [7:0] LR_3W_CONTACT = 8'h05;
    localparam logic [7:0] LR_3W_KEYPAD = 8'h2e;
    localparam logic [15:0] CFG_FOC_A = 16'h00e6;
    localparam logic [15:0] CFG_FOC_B = 16'h01ae;
    // timer modes, falling edge adds the offset
    localparam logic [7:0] TM_OFF = 8'h00;
    localparam logic [7:0] TM_NORMAL = 8'h01;
    localparam logic [7:0] TM_RETRIG = 8'h02;
    localparam logic [7:0] TM_AND = 8'h03;
    localparam logic [7:0] TM_FALL_OFS = 8'h0a;
    localparam logic [1:0] SET_CODE_1 = 2'h0;
    localparam logic [1:0] SET_CODE_2 = 2'h1;
    localparam logic [1:0] SET_CODE_3 = 2'h2;
    localparam logic [1:0] SET_CODE_4 = 2'h3;
    typedef enum logic [1:0] {T_IDLE, T_DELAY, T_ON} dcsl_tmr_e;
    typedef enum logic [1:0] {W_IDLE, W_READY, W_RUN, W_STOP} dcsl_tw_e;
endpackage

// *** rtl/dcsl_core.sv ***
// drive control signal logic: start, 3-wire, timers, selections
`timescale 1ns/1ps
`default_nettype none
module dcsl_core #(
    parameter int MsCycles = dcsl_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // contact inputs and internal logic signals
    input wire logic [dcsl_pkg::NUM_IN-1:0] digIn,
    input wire logic [dcsl_pkg::NUM_LOGIC-1:0] logicSig,
    // source select per function
    input wire logic [dcsl_pkg::NUM_FUNC-1:0][dcsl_pkg::SEL_W-1:0] funcSel,
    // configuration
    input wire logic [7:0] localRemote,
    input wire logic [15:0] configCode,
    input wire logic [1:0] startMode,
    input wire logic [1:0] stopMode,
    input wire logic [dcsl_pkg::NUM_TMR-1:0][7:0] tmrMode,
    input wire logic [dcsl_pkg::NUM_TMR-1:0][dcsl_pkg::TIME_W-1:0] tmrDelay,
    input wire logic [dcsl_pkg::NUM_TMR-1:0][dcsl_pkg::TIME_W-1:0] tmrDuration,
    input wire logic [dcsl_pkg::MP_W-1:0] mpInit,
    input wire logic [dcsl_pkg::MP_W-1:0] mpStep,
    // fault events
    input wire logic faultIn,
    input wire logic progWrite,
    // drive commands
    output logic runCmd,
    output logic dirCcw,
    output logic [1:0] startProfile,
    output logic [1:0] stopProfile,
    output logic threeWireOn,
    output logic startCheckTrip,
    output logic faultLatched,
    // routed selections
    output logic [dcsl_pkg::NUM_TMR-1:0] tmrOut,
    output logic thermoTrip,
    output logic torqueSel,
    output logic [1:0] activeDataSet,
    output logic [1:0] fixedFreqSel,
    output logic [1:0] fixedPctSel,
    output logic [dcsl_pkg::MP_W-1:0] mpValue
);
    import dcsl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // millisecond tick
    localparam logic [MS_CNT_W-1:0] MsLast = MS_CNT_W'(MsCycles - 1);
    logic [MS_CNT_W-1:0] msCnt_q;
    logic msTick;
    assign msTick = (msCnt_q == MsLast);
    always_ff @(posedge clock) begin
        if (!rst_n || msTick) begin
            msCnt_q <= '0;
        end else begin
            msCnt_q <= msCnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // signal pool and function sources
    logic [POOL_W-1:0] pool;
    logic [NUM_FUNC-1:0] fn;
    logic [NUM_TMR-1:0] tmrOut_q;
    assign pool[P_IN +: NUM_IN] = digIn;
    assign pool[P_INV +: NUM_IN] = ~digIn;
    assign pool[P_TMR +: NUM_TMR] = tmrOut_q;
    assign pool[P_LOGIC +: NUM_LOGIC] = logicSig;
    genvar f;
    generate
        for (f = 0; f < NUM_FUNC; f++) begin : gFunc
            assign fn[f] = pool[funcSel[f]];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // timers
    genvar t;
    generate
        for (t = 0; t < NUM_TMR; t++) begin : gTmr
            dcsl_tmr_e st_q;
            logic [TIME_W-1:0] cnt_q;
            logic prev_q;
            logic tin;
            logic fallMode;
            logic [7:0] base;
            logic edgeHit;
            logic bypass;
            assign tin = fn[F_T1 + t];
            assign fallMode = (tmrMode[t] > TM_AND);
            assign base = fallMode ? (tmrMode[t] - TM_FALL_OFS) : tmrMode[t];
            assign edgeHit = fallMode ? (prev_q & ~tin) : (~prev_q & tin);
            // zero delay and duration pass through
            assign bypass = (tmrDelay[t] == '0) && (tmrDuration[t] == '0);
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= tin;
                end
            end
            always_ff @(posedge clock) begin
                if (!rst_n || base == TM_OFF || base > TM_AND) begin
                    st_q <= T_IDLE;
                    cnt_q <= '0;
                    tmrOut_q[t] <= 1'b0;
                end else if (bypass) begin
                    st_q <= T_IDLE;
                    cnt_q <= '0;
                    tmrOut_q[t] <= tin;
                end else begin
                    case (st_q)
                        T_IDLE: begin
                            tmrOut_q[t] <= 1'b0;
                            cnt_q <= '0;
                            if (edgeHit) begin
                                st_q <= T_DELAY;
                            end
                        end
                        T_DELAY: begin
                            if (base != TM_NORMAL && edgeHit) begin
                                cnt_q <= '0;
                            end else if (base == TM_AND && !tin) begin
                                cnt_q <= '0;
                            end else if (cnt_q >= tmrDelay[t]) begin
                                st_q <= T_ON;
                                cnt_q <= '0;
                                tmrOut_q[t] <= 1'b1;
                            end else if (msTick) begin
                                cnt_q <= cnt_q + 1'b1;
                            end
                        end
                        T_ON: begin
                            if (base == TM_AND && !tin) begin
                                st_q <= T_IDLE;
                                tmrOut_q[t] <= 1'b0;
                            end else if (tmrDuration[t] == '0) begin
                                tmrOut_q[t] <= 1'b1;
                            end else if (cnt_q >= tmrDuration[t]) begin
                                st_q <= T_IDLE;
                                tmrOut_q[t] <= 1'b0;
                            end else if (msTick) begin
                                cnt_q <= cnt_q + 1'b1;
                            end
                        end
                        default: begin
                            st_q <= T_IDLE;
                        end
                    endcase
                end
            end
        end
    endgenerate
    assign tmrOut = tmrOut_q;

    ////////////////////////////////////////////////////////////////////
    // fault latch
    logic fault_q;
    logic ackPrev_q;
    logic ackRise;
    assign ackRise = fn[F_ACK] & ~ackPrev_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
            ackPrev_q <= 1'b0;
        end else begin
            ackPrev_q <= fn[F_ACK];
            // set wins, write or acknowledge clears
            if (faultIn) begin
                fault_q <= 1'b1;
            end else if (progWrite || ackRise) begin
                fault_q <= 1'b0;
            end
        end
    end
    assign faultLatched = fault_q;

    ////////////////////////////////////////////////////////////////////
    // start command and 3-wire control
    logic mode3w;
    logic enable3w;
    logic cwLvl;
    logic ccwLvl;
    logic cwPrev_q;
    logic ccwPrev_q;
    logic cwRise;
    logic ccwRise;
    logic latchLvl;
    logic otherLvl;
    logic inWindow;
    dcsl_tw_e tw_q;
    logic twDir_q;
    logic [PMS_W-1:0] pulseMs_q;
    logic trip_q;
    logic run_q;
    logic dir_q;
    logic [1:0] startProf_q;
    logic [1:0] stopProf_q;
    // 3-wire only for the two codes
    assign mode3w = (localRemote == LR_3W_CONTACT) || (localRemote == LR_3W_KEYPAD);
    assign enable3w = fn[F_3W];
    assign cwLvl = fn[F_CW];
    assign ccwLvl = fn[F_CCW];
    assign cwRise = cwLvl & ~cwPrev_q;
    assign ccwRise = ccwLvl & ~ccwPrev_q;
    assign latchLvl = twDir_q ? ccwLvl : cwLvl;
    assign otherLvl = twDir_q ? cwLvl : ccwLvl;
    assign inWindow = (pulseMs_q < PMS_W'(PULSE_MIN_MS));
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cwPrev_q <= 1'b0;
            ccwPrev_q <= 1'b0;
        end else begin
            cwPrev_q <= cwLvl;
            ccwPrev_q <= ccwLvl;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n || !mode3w) begin
            tw_q <= W_IDLE;
            twDir_q <= 1'b0;
            pulseMs_q <= '0;
            trip_q <= 1'b0;
        end else begin
            case (tw_q)
                W_IDLE: begin
                    trip_q <= 1'b0;
                    if (enable3w) begin
                        tw_q <= W_READY;
                    end
                end
                W_READY: begin
                    pulseMs_q <= '0;
                    if (!enable3w) begin
                        tw_q <= W_IDLE;
                    end else if (cwRise && ccwRise) begin
                        tw_q <= W_STOP;
                        trip_q <= 1'b1;
                    end else if ((cwRise || ccwRise) && !fault_q) begin
                        tw_q <= W_RUN;
                        twDir_q <= ccwRise;
                    end
                end
                W_RUN: begin
                    if (msTick && inWindow) begin
                        pulseMs_q <= pulseMs_q + 1'b1;
                    end
                    if (!enable3w) begin
                        tw_q <= W_IDLE;
                    end else if (fault_q) begin
                        tw_q <= W_STOP;
                    end else if (inWindow && !latchLvl) begin
                        tw_q <= W_STOP;
                        trip_q <= 1'b1;
                    end else if (inWindow && otherLvl) begin
                        tw_q <= W_STOP;
                        trip_q <= 1'b1;
                    end
                end
                W_STOP: begin
                    if (!enable3w) begin
                        tw_q <= W_IDLE;
                    end
                end
                default: begin
                    tw_q <= W_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (mode3w) begin
            // armed by level, started by pulse
            run_q <= (tw_q == W_RUN) && enable3w && !fault_q;
            dir_q <= twDir_q;
        end else begin
            // run only with a direction start
            run_q <= (cwLvl || ccwLvl) && !fault_q;
            dir_q <= ccwLvl && !cwLvl;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            startProf_q <= '0;
            stopProf_q <= '0;
        end else begin
            startProf_q <= startMode;
            stopProf_q <= stopMode;
        end
    end
    assign runCmd = run_q;
    assign dirCcw = dir_q;
    assign startProfile = startProf_q;
    assign stopProfile = stopProf_q;
    assign threeWireOn = mode3w;
    assign startCheckTrip = trip_q;

    ////////////////////////////////////////////////////////////////////
    // routed and coded selections
    logic focCfg;
    logic thermo_q;
    logic torque_q;
    logic [1:0] ds_q;
    logic [1:0] ff_q;
    logic [1:0] fp_q;
    logic [1:0] dsCode;
    logic [1:0] ffCode;
    logic [1:0] fpCode;
    function automatic logic [1:0] setCode(input logic a, input logic b);
        logic [1:0] r;
        r = SET_CODE_1;
        case ({a, b})
            2'b00: r = SET_CODE_1;
            2'b10: r = SET_CODE_2;
            2'b11: r = SET_CODE_3;
            2'b01: r = SET_CODE_4;
            default: r = SET_CODE_1;
        endcase
        return r;
    endfunction
    assign dsCode = setCode(fn[F_DS1], fn[F_DS2]);
    assign ffCode = setCode(fn[F_FF1], fn[F_FF2]);
    assign fpCode = setCode(fn[F_FP1], fn[F_FP2]);
    assign focCfg = (configCode == CFG_FOC_A) || (configCode == CFG_FOC_B);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            thermo_q <= 1'b0;
            torque_q <= 1'b0;
            ds_q <= SET_CODE_1;
            ff_q <= SET_CODE_1;
            fp_q <= SET_CODE_1;
        end else begin
            thermo_q <= fn[F_THERMO];
            torque_q <= focCfg && fn[F_NM];
            ds_q <= dsCode;
            ff_q <= ffCode;
            fp_q <= fpCode;
        end
    end
    assign thermoTrip = thermo_q;
    assign torqueSel = torque_q;
    assign activeDataSet = ds_q;
    assign fixedFreqSel = ff_q;
    assign fixedPctSel = fp_q;

    ////////////////////////////////////////////////////////////////////
    // motor potentiometer
    logic [MP_W-1:0] mp_q;
    logic [MP_W:0] mpUpSum;
    logic [MP_W:0] mpDnDiff;
    assign mpUpSum = {1'b0, mp_q} + {1'b0, mpStep};
    assign mpDnDiff = {1'b0, mp_q} - {1'b0, mpStep};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mp_q <= '0;
        end else begin
            // hold, ramp up, ramp down, reset
            case ({fn[F_MPUP], fn[F_MPDN]})
                2'b11: mp_q <= mpInit;
                2'b10: begin
                    if (msTick) begin
                        mp_q <= mpUpSum[MP_W] ? '1 : mpUpSum[MP_W-1:0];
                    end
                end
                2'b01: begin
                    if (msTick) begin
                        mp_q <= mpDnDiff[MP_W] ? '0 : mpDnDiff[MP_W-1:0];
                    end
                end
                default: mp_q <= mp_q;
            endcase
        end
    end
    assign mpValue = mp_q;
endmodule
`default_nettype wire

// *** dv/dcsl_core_assertions.sv ***
// concurrent checks on the ports of the control signal logic
`timescale 1ns/1ps
`default_nettype none
module dcsl_checker (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // inputs
    input wire logic [dcsl_pkg::NUM_IN-1:0] digIn,
    input wire logic [dcsl_pkg::NUM_LOGIC-1:0] logicSig,
    input wire logic [dcsl_pkg::NUM_FUNC-1:0][dcsl_pkg::SEL_W-1:0] funcSel,
    input wire logic [7:0] localRemote,
    input wire logic [1:0] startMode,
    input wire logic [dcsl_pkg::MP_W-1:0] mpInit,
    input wire logic faultIn,
    input wire logic progWrite,
    // outputs
    input wire logic runCmd,
    input wire logic [1:0] startProfile,
    input wire logic threeWireOn,
    input wire logic faultLatched,
    input wire logic [dcsl_pkg::NUM_TMR-1:0] tmrOut,
    input wire logic [1:0] activeDataSet,
    input wire logic [1:0] fixedFreqSel,
    input wire logic [dcsl_pkg::MP_W-1:0] mpValue
);
    import dcsl_pkg::*;
    logic [POOL_W-1:0] pool;
    logic [NUM_FUNC-1:0] fn;
    logic go;
    assign pool = {logicSig, tmrOut, ~digIn, digIn};
    assign go = fn[F_CW] | fn[F_CCW];
    always_comb begin
        for (int i = 0; i < NUM_FUNC; i++) begin
            fn[i] = pool[funcSel[i]];
        end
    end
    function automatic logic [1:0] code(input logic a, input logic b);
        return a ? (b ? 2'h2 : 2'h1) : (b ? 2'h3 : 2'h0);
    endfunction
    ////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence bothPot;
        fn[F_MPUP] && fn[F_MPDN];
    endsequence
    sequence enDrop;
        threeWireOn && $fell(fn[F_3W]);
    endsequence
    AST_PROFILE: assert property ($past(rst_n) |-> startProfile == $past(startMode))
        else $error("start profile does not follow start mode");
    AST_3W_CODE: assert property (threeWireOn == (localRemote == LR_3W_CONTACT ||
        localRemote == LR_3W_KEYPAD)) else $error("three wire mode on wrong code");
    AST_DSET: assert property ($past(rst_n) |->
        activeDataSet == code($past(fn[F_DS1]), $past(fn[F_DS2])))
        else $error("data set code wrong");
    AST_FFREQ: assert property ($past(rst_n) |->
        fixedFreqSel == code($past(fn[F_FF1]), $past(fn[F_FF2])))
        else $error("fixed frequency code wrong");
    AST_MP_RESET: assert property (bothPot |=> mpValue == $past(mpInit))
        else $error("motor pot not reset");
    AST_MP_HOLD: assert property (!fn[F_MPUP] && !fn[F_MPDN] |=> $stable(mpValue))
        else $error("motor pot moved while idle");
    AST_RUN_SRC: assert property ($rose(runCmd) |-> $past(go) || $past(go, 2) || $past(go, 3))
        else $error("run without start");
    AST_3W_STOP: assert property (enDrop |-> ##[1:2] !runCmd)
        else $error("enable off did not stop");
    AST_FLT_CLR: assert property (faultLatched && progWrite && !faultIn |=> !faultLatched)
        else $error("fault not cleared");
endmodule
bind dcsl_core dcsl_checker u_chk (.clock, .rst_n, .digIn, .logicSig, .funcSel, .localRemote,
    .startMode, .mpInit, .faultIn, .progWrite, .runCmd, .startProfile, .threeWireOn,
    .faultLatched, .tmrOut, .activeDataSet, .fixedFreqSel, .mpValue);
`default_nettype wire

// *** dv/dcsl_operator.sv ***
// operator contacts driving the digital inputs
`timescale 1ns/1ps
`default_nettype none
module dcsl_operator (
    // clock
    input wire logic clock,
    // requested contact states
    input wire logic [dcsl_pkg::NUM_IN-1:0] press,
    // contact lines
    output logic [dcsl_pkg::NUM_IN-1:0] digIn
);
    import dcsl_pkg::*;
    always_ff @(posedge clock) begin
        digIn <= press;
    end
endmodule
`default_nettype wire

// *** dv/drive_control_signal_logic_tb.sv ***
// self-checking bench of the control signal logic
`timescale 1ns/1ps
`default_nettype none
module drive_control_signal_logic_tb;
    import dcsl_pkg::*;
    localparam int MSC = 10;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [NUM_IN-1:0] press = '0;
    logic [NUM_IN-1:0] digIn;
    logic [NUM_LOGIC-1:0] logicSig = '0;
    logic [NUM_FUNC-1:0][SEL_W-1:0] funcSel = '0;
    logic [7:0] localRemote = '0;
    logic [15:0] configCode = CFG_FOC_A;
    logic [1:0] startMode = '0;
    logic [1:0] stopMode = '0;
    logic [NUM_TMR-1:0][7:0] tmrMode = '0;
    logic [NUM_TMR-1:0][TIME_W-1:0] tmrDelay = '0;
    logic [NUM_TMR-1:0][TIME_W-1:0] tmrDuration = '0;
    logic [MP_W-1:0] mpInit = '0;
    logic [MP_W-1:0] mpStep = 16'h0010;
    logic faultIn = 1'b0;
    logic progWrite = 1'b0;
    logic runCmd, dirCcw, threeWireOn, startCheckTrip, faultLatched, thermoTrip, torqueSel;
    logic [1:0] startProfile, stopProfile, activeDataSet, fixedFreqSel, fixedPctSel;
    logic [NUM_TMR-1:0] tmrOut;
    logic [MP_W-1:0] mpValue;
    logic [7:0] lrv [8] = '{8'h05, 8'h2e, 8'h00, 8'h04, 8'h06, 8'h2d, 8'h2f, 8'hff};
    int fails = 0;
    int comparisons = 0;
    always #2.5 clock = ~clock;
    dcsl_operator OPR (.clock, .press, .digIn);
    dcsl_core #(.MsCycles(MSC)) DUT (.clock, .rst_n, .digIn, .logicSig, .funcSel,
        .localRemote, .configCode, .startMode, .stopMode, .tmrMode, .tmrDelay, .tmrDuration,
        .mpInit, .mpStep, .faultIn, .progWrite, .runCmd, .dirCcw, .startProfile, .stopProfile,
        .threeWireOn, .startCheckTrip, .faultLatched, .tmrOut, .thermoTrip, .torqueSel,
        .activeDataSet, .fixedFreqSel, .fixedPctSel, .mpValue);
    ////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chkBit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic src(input int f);
        logic [15:0] p;
        p = {logicSig, 2'b00, ~digIn, digIn};
        return p[funcSel[f]];
    endfunction
    function automatic logic [1:0] code(input logic a, input logic b);
        return a ? (b ? 2'h2 : 2'h1) : (b ? 2'h3 : 2'h0);
    endfunction
    // tests need under 1500 cycles, so this span of 40000 cycles is generous
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
    initial begin
        logic [3:0] v;
        logic [15:0] m;
        void'($urandom(32'h8492));
        repeat (8) @(posedge clock);
        #1;
        chkBit(runCmd, 1'b0);
        chkVal(mpValue, 16'h0);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            localRemote = lrv[i];
            step(1);
            chkBit(threeWireOn, i < 2);
        end
        localRemote = 8'h00;
        for (int i = 0; i < 60; i++) begin
            for (int f = F_THERMO; f <= F_FP2; f++) begin
                v = 4'($urandom_range(13));
                funcSel[f] = v > 4'hb ? v + 4'h2 : v;
            end
            press = NUM_IN'($urandom) & 6'h38;
            logicSig = 2'($urandom);
            startMode = 2'($urandom);
            stopMode = 2'($urandom);
            configCode = i[0] ? CFG_FOC_B : (i[1] ? CFG_FOC_A : 16'h006e);
            step(2);
            chkVal(16'(activeDataSet), 16'(code(src(F_DS1), src(F_DS2))));
            chkVal(16'(fixedFreqSel), 16'(code(src(F_FF1), src(F_FF2))));
            chkVal(16'(fixedPctSel), 16'(code(src(F_FP1), src(F_FP2))));
            chkBit(thermoTrip, src(F_THERMO));
            chkBit(torqueSel, src(F_NM) & (i[1:0] != 2'b00));
            chkVal(16'({startProfile, stopProfile}), 16'({startMode, stopMode}));
        end
        $display("selection test done");
        funcSel[F_T1] = 4'(IN_FOUR);
        funcSel[F_DS1] = 4'(P_TMR);
        funcSel[F_DS2] = 4'(P_LOGIC);
        logicSig = 2'b00;
        tmrMode[0] = TM_NORMAL;
        for (int i = 0; i < 4; i++) begin
            press = {2'b00, i[0], 3'b000};
            step(4);
            chkVal(16'(activeDataSet), 16'(code(i[0], 1'b0)));
            chkVal(16'(tmrOut), 16'(i[0]));
        end
        funcSel[F_T2] = 4'(P_LOGIC + 1);
        tmrMode[1] = TM_FALL_OFS + TM_NORMAL;
        tmrDelay[1] = 16'h0002;
        tmrDuration[1] = 16'h0003;
        logicSig = 2'b10;
        step(1);
        logicSig = 2'b00;
        step(5);
        chkVal(16'(tmrOut), 16'h0001);
        step(20);
        chkVal(16'(tmrOut), 16'h0003);
        step(35);
        chkVal(16'(tmrOut), 16'h0001);
        $display("timer test done");
        funcSel[F_MPUP] = 4'h0e;
        funcSel[F_MPDN] = 4'h0f;
        mpInit = 16'h1000 + 16'($urandom_range(16'hd000));
        logicSig = 2'b11;
        step(2);
        chkVal(mpValue, mpInit);
        logicSig = 2'b00;
        step(30);
        chkVal(mpValue, mpInit);
        logicSig = 2'b01;
        step(5 * MSC);
        m = mpValue - mpInit;
        chkBit(m inside {16'h40, 16'h50, 16'h60}, 1'b1);
        logicSig = 2'b10;
        step(5 * MSC);
        m = mpInit + m - mpValue;
        chkBit(m inside {16'h40, 16'h50, 16'h60}, 1'b1);
        logicSig = 2'b00;
        $display("motor pot test done");
        funcSel[F_CW] = 4'h0;
        funcSel[F_CCW] = 4'h1;
        funcSel[F_3W] = 4'h2;
        funcSel[F_ACK] = 4'h5;
        press = '0;
        localRemote = LR_3W_CONTACT;
        step(3);
        press[0] = 1'b1;
        step(10);
        chkBit(runCmd, 1'b0);
        press[0] = 1'b0;
        press[2] = 1'b1;
        step(3);
        press[0] = 1'b1;
        step(400);
        chkVal(16'({runCmd, dirCcw, startCheckTrip}), 16'h0004);
        press[0] = 1'b0;
        step(5);
        chkBit(runCmd, 1'b1);
        press[1] = 1'b1;
        step(400);
        chkVal(16'({runCmd, dirCcw}), 16'h0002);
        press[1] = 1'b0;
        press[2] = 1'b0;
        step(4);
        chkBit(runCmd, 1'b0);
        press[2] = 1'b1;
        step(3);
        press[1] = 1'b1;
        step(50);
        press[1] = 1'b0;
        step(6);
        chkVal(16'({runCmd, startCheckTrip}), 16'h0001);
        press[2] = 1'b0;
        step(6);
        chkBit(startCheckTrip, 1'b0);
        press[2] = 1'b1;
        step(3);
        press[0] = 1'b1;
        step(100);
        press[1] = 1'b1;
        step(6);
        chkVal(16'({runCmd, startCheckTrip}), 16'h0001);
        press = '0;
        step(6);
        $display("three wire test done");
        localRemote = 8'h00;
        press[1] = 1'b1;
        step(3);
        chkVal(16'({runCmd, dirCcw}), 16'h0003);
        press = 6'h01;
        step(3);
        chkVal(16'({runCmd, dirCcw}), 16'h0002);
        press = '0;
        faultIn = 1'b1;
        step(1);
        faultIn = 1'b0;
        step(3);
        chkVal(16'({runCmd, faultLatched}), 16'h0001);
        progWrite = 1'b1;
        step(1);
        progWrite = 1'b0;
        step(1);
        chkBit(faultLatched, 1'b0);
        faultIn = 1'b1;
        progWrite = 1'b1;
        step(1);
        progWrite = 1'b0;
        faultIn = 1'b0;
        step(1);
        chkBit(faultLatched, 1'b1);
        press[5] = 1'b1;
        step(3);
        chkBit(faultLatched, 1'b0);
        $display("direct and fault test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
